//--- logic/tpio_defines.svh
// reset values, field positions and widths for the three-port io block
`ifndef TPIO_DEFINES_SVH
`define TPIO_DEFINES_SVH

`define TPIO_P2_WIDTH        3
`define TPIO_P2_LATCH_RST    3'h7
`define TPIO_P3_DIR_RST      8'h00
`define TPIO_P3_LATCH_RST    8'h00
`define TPIO_P4_DIR_RST      8'h00
`define TPIO_P4_LATCH_RST    8'h00
`define TPIO_AIN_DIS_RST     1'b1
`define TPIO_CHAN_RST        3'h0
`define TPIO_CONV_CHAN_LSB   0
`define TPIO_CONV_CHAN_MSB   2
`define TPIO_CONV_AIN_DIS    4
`define TPIO_INT_PIN         0
`define TPIO_XTAL_IN_PIN     1
`define TPIO_XTAL_OUT_PIN    2

`endif

//--- logic/tpio_pkg.sv
// types shared by the three-port io block
`default_nettype none
package tpio_pkg;

    typedef enum logic [2:0] {
        TPIO_SEL_P2_LATCH = 3'h0,
        TPIO_SEL_P2_PIN   = 3'h1,
        TPIO_SEL_P3_DATA  = 3'h2,
        TPIO_SEL_P3_DIR   = 3'h3,
        TPIO_SEL_P4_DATA  = 3'h4,
        TPIO_SEL_P4_DIR   = 3'h5,
        TPIO_SEL_CONV     = 3'h6,
        TPIO_SEL_NONE     = 3'h7
    } tpio_sel_t;

    typedef struct packed {
        logic       en;
        tpio_sel_t  sel;
        logic [7:0] data;
    } tpio_wr_t;

    typedef struct packed {
        logic       en;
        tpio_sel_t  sel;
    } tpio_rd_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } tpio_rdata_t;

endpackage : tpio_pkg

`default_nettype wire

//--- logic/tpio_port8.sv
// one 8-bit port with direction bits and an analog override mask
`timescale 1ns/10ps
`default_nettype none

module tpio_port8 (
    // control
    input  wire logic [7:0] dir_i,
    input  wire logic [7:0] latch_i,
    input  wire logic [7:0] analog_mask_i,
    // pins
    input  wire logic [7:0] pin_in_i,
    output logic      [7:0] pin_out_o,
    output logic      [7:0] pin_oe_n_o,
    // readback
    output logic      [7:0] read_o
);

    wire [7:0] digital = ~analog_mask_i;
    wire [7:0] drive   = dir_i & digital;

    assign pin_out_o  = latch_i;
    assign pin_oe_n_o = ~drive;
    // output bits read the latch, input bits the pin, analog pins read zero
    assign read_o     = (drive & latch_i) | (~dir_i & digital & pin_in_i);

endmodule : tpio_port8

`default_nettype wire

//--- logic/tpio_top.sv
// three-port parallel io block: 3-bit shared port and two 8-bit ports
`timescale 1ns/10ps
`default_nettype none
`include "tpio_defines.svh"

module tpio_top (
    // clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 ce_i,
    // register access
    input  wire tpio_pkg::tpio_wr_t   wr_i,
    input  wire tpio_pkg::tpio_rd_t   rd_i,
    output tpio_pkg::tpio_rdata_t     rdata_o,
    // clock mode and crystal
    input  wire logic                 dual_clock_mode_i,
    input  wire logic                 lowfreq_xtal_drive_i,
    output logic                      lowfreq_xtal_in_o,
    // 3-bit shared port pins
    input  wire logic [2:0]           p2_pin_i,
    output logic      [2:0]           p2_pin_o,
    output logic      [2:0]           p2_pin_oe_n_o,
    output logic                      int0_fall_o,
    // analog-shared port pins
    input  wire logic [7:0]           p3_pin_i,
    output logic      [7:0]           p3_pin_o,
    output logic      [7:0]           p3_pin_oe_n_o,
    // converter control view
    output logic                      analog_input_disable_o,
    output logic      [2:0]           analog_channel_select_o,
    // plain port pins
    input  wire logic [7:0]           p4_pin_i,
    output logic      [7:0]           p4_pin_o,
    output logic      [7:0]           p4_pin_oe_n_o
);
    import tpio_pkg::*;

    logic [2:0] port_two_out_latch_q;
    logic [7:0] port_three_out_latch_q;
    logic [7:0] port_three_dir_ctrl_q;
    logic [7:0] port_four_out_latch_q;
    logic [7:0] port_four_dir_ctrl_q;
    logic       analog_input_disable_q;
    logic [2:0] analog_channel_select_q;
    logic       int_pin_prev_q;
    logic       int0_fall_q;
    tpio_rdata_t rdata_q;
    tpio_rdata_t rdata_d;

    // write decode
    wire wr_p2_latch = ce_i && wr_i.en && (wr_i.sel == TPIO_SEL_P2_LATCH);
    wire wr_p3_latch = ce_i && wr_i.en && (wr_i.sel == TPIO_SEL_P3_DATA);
    wire wr_p3_dir   = ce_i && wr_i.en && (wr_i.sel == TPIO_SEL_P3_DIR);
    wire wr_p4_latch = ce_i && wr_i.en && (wr_i.sel == TPIO_SEL_P4_DATA);
    wire wr_p4_dir   = ce_i && wr_i.en && (wr_i.sel == TPIO_SEL_P4_DIR);
    wire wr_conv     = ce_i && wr_i.en && (wr_i.sel == TPIO_SEL_CONV);

    // analog override: one-hot pin when the converter is enabled
    wire [7:0] analog_mask = analog_input_disable_q ? 8'h00 :
                             (8'h01 << analog_channel_select_q);

    wire [7:0] p3_read;
    wire [7:0] p4_read;

    tpio_port8 u_port_three (
        .dir_i         (port_three_dir_ctrl_q),
        .latch_i       (port_three_out_latch_q),
        .analog_mask_i (analog_mask),
        .pin_in_i      (p3_pin_i),
        .pin_out_o     (p3_pin_o),
        .pin_oe_n_o    (p3_pin_oe_n_o),
        .read_o        (p3_read)
    );

    tpio_port8 u_port_four (
        .dir_i         (port_four_dir_ctrl_q),
        .latch_i       (port_four_out_latch_q),
        .analog_mask_i (8'h00),
        .pin_in_i      (p4_pin_i),
        .pin_out_o     (p4_pin_o),
        .pin_oe_n_o    (p4_pin_oe_n_o),
        .read_o        (p4_read)
    );

    // 3-bit port: sink low when the latch is zero, release when one; in dual mode bit 1 is released and bit 2 carries the crystal drive
    wire xtal_mode = dual_clock_mode_i;
    assign p2_pin_o[0]      = port_two_out_latch_q[0];
    assign p2_pin_oe_n_o[0] = port_two_out_latch_q[0];
    assign p2_pin_o[1]      = port_two_out_latch_q[1];
    assign p2_pin_oe_n_o[1] = xtal_mode | port_two_out_latch_q[1];
    assign p2_pin_o[2]      = xtal_mode ? lowfreq_xtal_drive_i : port_two_out_latch_q[2];
    assign p2_pin_oe_n_o[2] = xtal_mode ? 1'b0 : port_two_out_latch_q[2];
    assign lowfreq_xtal_in_o = xtal_mode & p2_pin_i[`TPIO_XTAL_IN_PIN];

    assign analog_input_disable_o  = analog_input_disable_q;
    assign analog_channel_select_o = analog_channel_select_q;
    assign int0_fall_o             = int0_fall_q;
    assign rdata_o                 = rdata_q;

    // read selection; upper bits of the 3-bit port read as zero
    always_comb begin
        rdata_d.valid = rd_i.en;
        unique case (rd_i.sel)
            TPIO_SEL_P2_LATCH: rdata_d.data = {5'h00, port_two_out_latch_q};
            TPIO_SEL_P2_PIN:   rdata_d.data = {5'h00, p2_pin_i};
            TPIO_SEL_P3_DATA:  rdata_d.data = p3_read;
            TPIO_SEL_P3_DIR:   rdata_d.data = port_three_dir_ctrl_q;
            TPIO_SEL_P4_DATA:  rdata_d.data = p4_read;
            TPIO_SEL_P4_DIR:   rdata_d.data = port_four_dir_ctrl_q;
            TPIO_SEL_CONV:     rdata_d.data = {3'h0, analog_input_disable_q,
                                               1'b0, analog_channel_select_q};
            TPIO_SEL_NONE:     rdata_d.data = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_two_out_latch_q <= `TPIO_P2_LATCH_RST;
        end else if (wr_p2_latch) begin
            port_two_out_latch_q <= wr_i.data[2:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_three_out_latch_q <= `TPIO_P3_LATCH_RST;
            port_three_dir_ctrl_q  <= `TPIO_P3_DIR_RST;
        end else begin
            if (wr_p3_latch) begin
                port_three_out_latch_q <= wr_i.data;
            end
            if (wr_p3_dir) begin
                port_three_dir_ctrl_q <= wr_i.data;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_four_out_latch_q <= `TPIO_P4_LATCH_RST;
            port_four_dir_ctrl_q  <= `TPIO_P4_DIR_RST;
        end else begin
            if (wr_p4_latch) begin
                port_four_out_latch_q <= wr_i.data;
            end
            if (wr_p4_dir) begin
                port_four_dir_ctrl_q <= wr_i.data;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            analog_input_disable_q  <= `TPIO_AIN_DIS_RST;
            analog_channel_select_q <= `TPIO_CHAN_RST;
        end else if (wr_conv) begin
            analog_input_disable_q  <= wr_i.data[`TPIO_CONV_AIN_DIS];
            analog_channel_select_q <= wr_i.data[`TPIO_CONV_CHAN_MSB:`TPIO_CONV_CHAN_LSB];
        end
    end

    // falling edge of the bit 0 pin level, driven or not
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            int_pin_prev_q <= 1'b1;
            int0_fall_q    <= 1'b0;
        end else if (ce_i) begin
            int_pin_prev_q <= p2_pin_i[`TPIO_INT_PIN];
            int0_fall_q    <= int_pin_prev_q & ~p2_pin_i[`TPIO_INT_PIN];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= '0;
        end else if (ce_i) begin
            rdata_q <= rdata_d;
        end
    end

    a_p2_reset_ones: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> port_two_out_latch_q == `TPIO_P2_LATCH_RST)
        else $error("3-bit latch not all ones after reset");

    a_reset_inputs: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> (p3_pin_oe_n_o == 8'hFF) && analog_input_disable_q
                            && (p4_pin_oe_n_o == 8'hFF) && (p4_pin_o == 8'h00))
        else $error("ports not inputs after reset");

    a_xtal_released: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        dual_clock_mode_i |-> p2_pin_oe_n_o[1] && !p2_pin_oe_n_o[2]
                              && (p2_pin_o[2] == lowfreq_xtal_drive_i))
        else $error("crystal pins not handed over");

    a_int_fall_seen: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ce_i && !p2_pin_oe_n_o[0] && $past(p2_pin_i[0]) && !p2_pin_i[0] && $past(ce_i)
        |=> int0_fall_o)
        else $error("driven falling edge on bit 0 missed");

    a_p2_pin_read: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ce_i && rd_i.en && (rd_i.sel == TPIO_SEL_P2_PIN)
        |=> rdata_o.valid && (rdata_o.data == {5'h00, $past(p2_pin_i)}))
        else $error("3-bit pin read wrong");

    a_p2_latch_write: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_p2_latch |=> port_two_out_latch_q == $past(wr_i.data[2:0]))
        else $error("3-bit latch write not taken on its edge");

    a_analog_pin_off: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !analog_input_disable_q |-> p3_pin_oe_n_o[analog_channel_select_q])
        else $error("analog pin still driven");

    a_analog_read_zero: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ce_i && rd_i.en && (rd_i.sel == TPIO_SEL_P3_DATA) && !analog_input_disable_q
        |=> rdata_o.data[$past(analog_channel_select_q)] == 1'b0)
        else $error("analog pin read not zero");

    a_p3_dir_drive: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        analog_input_disable_q |-> p3_pin_oe_n_o == ~port_three_dir_ctrl_q)
        else $error("analog port direction not honoured");

    a_input_latch_write: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_p3_latch && (port_three_dir_ctrl_q == 8'h00)
        |=> port_three_out_latch_q == $past(wr_i.data))
        else $error("latch write refused for input bits");

    a_p4_mixed_read: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ce_i && rd_i.en && (rd_i.sel == TPIO_SEL_P4_DATA)
        |=> rdata_o.data == $past((port_four_dir_ctrl_q & port_four_out_latch_q)
                                  | (~port_four_dir_ctrl_q & p4_pin_i)))
        else $error("plain port mixed read wrong");

    a_p4_dir_bits: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_p4_dir |=> p4_pin_oe_n_o == ~$past(wr_i.data))
        else $error("plain port direction not applied next cycle");

    // clock enable low holds every register, so a write in that cycle is lost
    a_ce_freeze: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !ce_i |=> $stable(port_two_out_latch_q) && $stable(port_three_out_latch_q)
                  && $stable(port_four_out_latch_q) && $stable(port_four_dir_ctrl_q)
                  && $stable(analog_input_disable_q) && $stable(rdata_o))
        else $error("register changed while clock enable low");

    a_int_fall_only: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        int0_fall_o && $past(ce_i) |-> !$past(p2_pin_i[0]))
        else $error("edge pulse without a low pin level");

    a_p3_dir_write: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_p3_dir |=> port_three_dir_ctrl_q == $past(wr_i.data))
        else $error("analog port direction write not taken on its edge");

    a_conv_write: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_conv |=> (analog_input_disable_o == $past(wr_i.data[`TPIO_CONV_AIN_DIS]))
                    && (analog_channel_select_o == $past(wr_i.data[2:0])))
        else $error("converter control write not taken");

    a_p4_latch_any_dir: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_p4_latch |=> p4_pin_o == $past(wr_i.data))
        else $error("plain port latch write refused");

    a_p2_plain_drive: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !dual_clock_mode_i |-> (p2_pin_oe_n_o == port_two_out_latch_q)
                               && (p2_pin_o == port_two_out_latch_q))
        else $error("3-bit port not plain io in single-clock mode");

    a_analog_one_pin: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !analog_input_disable_q && (port_three_dir_ctrl_q == 8'hFF)
        |-> $countones(p3_pin_oe_n_o) == 1)
        else $error("analog override reaches more than one pin");

    a_rd_idle: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ce_i && !rd_i.en |=> !rdata_o.valid)
        else $error("read data marked valid without a read");

endmodule : tpio_top

`default_nettype wire

//--- bench/tpio_board.sv
// board model: resolves each port pin from the block's drive and the board's own levels
`timescale 1ns/10ps
`default_nettype none

module tpio_board (
    // block side
    input  wire logic [2:0] p2_o_i,
    input  wire logic [2:0] p2_oe_n_i,
    input  wire logic [7:0] p3_o_i,
    input  wire logic [7:0] p3_oe_n_i,
    input  wire logic [7:0] p4_o_i,
    input  wire logic [7:0] p4_oe_n_i,
    // board drive for released pins
    input  wire logic [7:0] p3_ext_i,
    input  wire logic [7:0] p4_ext_i,
    // resolved pin levels
    output logic      [2:0] p2_pin_o,
    output logic      [7:0] p3_pin_o,
    output logic      [7:0] p4_pin_o
);
    // the 3-bit port is open drain with pull-ups, so a released pin reads one
    assign p2_pin_o = (p2_o_i & ~p2_oe_n_i) | p2_oe_n_i;
    assign p3_pin_o = (p3_o_i & ~p3_oe_n_i) | (p3_ext_i & p3_oe_n_i);
    assign p4_pin_o = (p4_o_i & ~p4_oe_n_i) | (p4_ext_i & p4_oe_n_i);
endmodule : tpio_board

`default_nettype wire

//--- bench/tb_top.sv
// self-checking testbench for the three-port io block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import tpio_pkg::*;

    logic        ref_clk_i, resetn_i, ce_i, dual, xdrv, xin, fall;
    tpio_wr_t    wr_i;
    tpio_rd_t    rd_i;
    tpio_rdata_t rdata_o;
    logic [2:0]  p2_pin, p2_o, p2_oe_n;
    logic [7:0]  p3_pin, p3_o, p3_oe_n, p4_pin, p4_o, p4_oe_n;
    logic [7:0]  p3_ext, p4_ext;
    logic [2:0]  chan;
    logic        dis;
    int          mismatches, n_checks, k;

    tpio_top tpio_top_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dual_clock_mode_i(dual),
        .lowfreq_xtal_drive_i(xdrv), .lowfreq_xtal_in_o(xin), .p2_pin_i(p2_pin),
        .p2_pin_o(p2_o), .p2_pin_oe_n_o(p2_oe_n), .int0_fall_o(fall), .p3_pin_i(p3_pin),
        .p3_pin_o(p3_o), .p3_pin_oe_n_o(p3_oe_n), .analog_input_disable_o(dis),
        .analog_channel_select_o(chan), .p4_pin_i(p4_pin), .p4_pin_o(p4_o),
        .p4_pin_oe_n_o(p4_oe_n));

    tpio_board tpio_board_inst (.p2_o_i(p2_o), .p2_oe_n_i(p2_oe_n), .p3_o_i(p3_o),
        .p3_oe_n_i(p3_oe_n), .p4_o_i(p4_o), .p4_oe_n_i(p4_oe_n), .p3_ext_i(p3_ext),
        .p4_ext_i(p4_ext), .p2_pin_o(p2_pin), .p3_pin_o(p3_pin), .p4_pin_o(p4_pin));

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input tpio_sel_t s, input logic [7:0] d);
        @(negedge ref_clk_i);
        wr_i = '{1'b1, s, d};
        @(negedge ref_clk_i);
        wr_i.en = 1'b0;
    endtask : wr

    task automatic rd(input tpio_sel_t s, input logic [7:0] exp);
        @(negedge ref_clk_i);
        rd_i = '{1'b1, s};
        @(negedge ref_clk_i);
        rd_i.en = 1'b0;
        chk({7'h00, rdata_o.valid}, 8'h01);
        chk(rdata_o.data, exp);
    endtask : rd

    task automatic results;
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    initial begin
        #(100 * 3000);
        mismatches++;
        results();
    end

    initial begin
        mismatches = 0;
        n_checks = 0;
        resetn_i = 1'b0;
        ce_i = 1'b1;
        dual = 1'b0;
        xdrv = 1'b0;
        wr_i = '{1'b0, TPIO_SEL_NONE, 8'h00};
        rd_i = '{1'b0, TPIO_SEL_NONE};
        p3_ext = 8'hC3;
        p4_ext = 8'h3C;
        repeat (4) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        // reset state
        rd(TPIO_SEL_P2_LATCH, 8'h07);
        rd(TPIO_SEL_CONV, 8'h10);
        rd(TPIO_SEL_P3_DIR, 8'h00);
        rd(TPIO_SEL_P4_DIR, 8'h00);
        rd(TPIO_SEL_P4_DATA, 8'h3C);
        chk(p4_o, 8'h00);
        chk({3'h0, dis, 1'b0, chan}, 8'h10);
        chk({p3_oe_n}, 8'hFF);
        // bit 0 driven low only to see the edge latch work
        wr(TPIO_SEL_P2_LATCH, 8'h06);
        k = 0;
        repeat (4) begin
            @(negedge ref_clk_i);
            if (fall === 1'b1) k++;
        end
        chk(k[7:0], 8'h01);
        rd(TPIO_SEL_P2_LATCH, 8'h06);
        rd(TPIO_SEL_P2_PIN, 8'h06);
        wr(TPIO_SEL_P2_LATCH, 8'h07);
        // crystal owns bits 1 and 2 in dual mode
        dual = 1'b1;
        @(negedge ref_clk_i);
        chk({5'h00, p2_oe_n}, 8'h03);
        chk({7'h00, xin}, 8'h01);
        chk({5'h00, p2_o}, 8'h03);
        rd(TPIO_SEL_P2_PIN, 8'h03);
        xdrv = 1'b1;
        rd(TPIO_SEL_P2_PIN, 8'h07);
        chk({5'h00, p2_o}, 8'h07);
        dual = 1'b0;
        wr(TPIO_SEL_P2_LATCH, 8'h05);
        chk({5'h00, p2_oe_n}, 8'h05);
        rd(TPIO_SEL_P2_PIN, 8'h05);
        // plain port: latch first, then direction
        wr(TPIO_SEL_P4_DATA, 8'hA5);
        chk(p4_oe_n, 8'hFF);
        wr(TPIO_SEL_P4_DIR, 8'h0F);
        chk(p4_oe_n, 8'hF0);
        chk(p4_o, 8'hA5);
        rd(TPIO_SEL_P4_DATA, 8'h35);
        wr(TPIO_SEL_P4_DATA, 8'h3C);
        wr(TPIO_SEL_P4_DIR, 8'hFF);
        rd(TPIO_SEL_P4_DATA, 8'h3C);
        // clock enable low: the write is lost and the port holds
        ce_i = 1'b0;
        wr(TPIO_SEL_P4_DATA, 8'hC3);
        chk(p4_o, 8'h3C);
        ce_i = 1'b1;
        rd(TPIO_SEL_P4_DATA, 8'h3C);
        // second reset in mid-run brings written registers back
        resetn_i = 1'b0;
        @(negedge ref_clk_i);
        resetn_i = 1'b1;
        chk(p4_o, 8'h00);
        chk(p4_oe_n, 8'hFF);
        chk({5'h00, p2_oe_n}, 8'h07);
        // analog port with channel 3 taken by the converter
        wr(TPIO_SEL_P3_DATA, 8'h5D);
        wr(TPIO_SEL_P3_DIR, 8'hFF);
        chk(p3_oe_n, 8'h00);
        chk(p3_o, 8'h5D);
        wr(TPIO_SEL_CONV, 8'h03);
        chk({3'h0, dis, 1'b0, chan}, 8'h03);
        chk(p3_oe_n, 8'h08);
        rd(TPIO_SEL_P3_DATA, 8'h55);
        wr(TPIO_SEL_P3_DIR, 8'h0F);
        rd(TPIO_SEL_P3_DATA, 8'hC5);
        wr(TPIO_SEL_CONV, 8'h13);
        chk({3'h0, dis, 1'b0, chan}, 8'h13);
        chk(p3_oe_n, 8'hF0);
        rd(TPIO_SEL_P3_DATA, 8'hCD);
        results();
    end
endmodule : tb_top

`default_nettype wire
